// *** dv/ext_mem_model.sv ***
module ext_mem_model
(
  input wire logic core_clk,
  input wire logic [20:0] ext_addr,
  input wire logic ext_enable,
  output logic [15:0] ext_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] noise = 16'h0;
  // an idle bus floats, so never repeat the last word
  always @(posedge core_clk) noise <= noise + 16'h3c5b;
  assign ext_word = ext_enable ? (ext_addr[15:0] ^ 16'h5a5a) : noise;
endmodule // ext_mem_model

// *** dv/pmem_decoder_tb.sv ***
`define CMP(n, e, g) if ((e) !== (g)) \
  begin \
    $display("unexpected %s: expected %h, seen %h", n, e, g); \
    miscompares++; \
  end \
  n_compared++;
module pmem_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // small flash keeps the config area easy to reach
  localparam logic [20:0] FSZ = 21'h008000;
  typedef struct packed {logic [3:0] s; logic [20:0] e;} note_type;
  logic core_clk = 1'b0, srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, data_addr = 8'h0;
  logic reg_write = 1'b0, reg_read = 1'b0, pc_load = 1'b0, pc_step = 1'b0;
  logic irq_high = 1'b0, irq_low = 1'b0, data_write = 1'b0;
  logic [20:0] pc_target = 21'h0, table_addr = 21'h0, pc, flash_addr;
  logic [20:0] ext_addr;
  logic [15:0] fetch_word, flash_word, ext_word;
  logic fetch_external, table_external, table_zero, config_ready;
  logic ext_enable, ext_wide, ext_wait_enable;
  logic [1:0] ext_wait_count, m;
  logic [7:0] data_wdata = 8'h0, data_rdata, v, mc;
  logic [7:0] cfg [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77,
    8'h88};
  logic [20:0] obs [13];
  string nm [13] = '{"pc", "reg_rdata", "fetch_word", "table_external",
    "table_zero", "ext_addr", "ext_enable", "ext_wide", "ext_wait_enable",
    "ext_wait_count", "data_rdata", "fetch_external", "config_ready"};
  note_type q [$];
  event look;
  int miscompares = 0, n_compared = 0, cycles = 0;
  always #20 core_clk = ~core_clk;
  pmem_decoder #(.FLASH_SIZE(FSZ), .PIN80(1'b1)) DUT (.core_clk, .srst,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pc_load,
    .pc_target, .pc_step, .irq_high, .irq_low, .pc, .fetch_word,
    .fetch_external, .table_addr, .table_external, .table_zero, .flash_addr,
    .flash_word, .ext_addr, .ext_enable, .ext_wide, .ext_wait_enable,
    .ext_wait_count, .ext_word, .data_addr, .data_write, .data_wdata,
    .data_rdata, .config_ready);
  ext_mem_model u_ext (.core_clk, .ext_addr, .ext_enable, .ext_word);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fbyte(logic [20:0] a);
    if (a >= FSZ - 21'h8 && a < FSZ) return cfg[a[2:0]];
    return a[7:0] ^ a[15:8];
  endfunction
  always_comb flash_word = {fbyte({flash_addr[20:1], 1'b1}),
    fbyte({flash_addr[20:1], 1'b0})};
  always_comb obs = '{pc, 21'(reg_rdata), 21'(fetch_word),
    21'(table_external), 21'(table_zero), ext_addr, 21'(ext_enable),
    21'(ext_wide), 21'(ext_wait_enable), 21'(ext_wait_count),
    21'(data_rdata), 21'(fetch_external), 21'(config_ready)};
  initial
  begin
    note_type n;
    forever
    begin
      @(look);
      while (q.size() > 0)
      begin
        n = q.pop_front();
        `CMP(nm[n.s], n.e, obs[n.s])
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a hang costs a mismatch; the whole run needs well under 2000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic tick(int k = 1);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic note(int s, logic [20:0] e);
    q.push_back({4'(s), e});
    ->look;
  endtask
  task automatic reg_rd(logic [3:0] a, logic [7:0] e);
    tick();
    reg_addr <= a;
    reg_read <= 1'b1;
    tick();
    reg_read <= 1'b0;
    #1;
    note(1, 21'(e));
  endtask
  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    tick();
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    tick();
    reg_write <= 1'b0;
  endtask
  task automatic do_reset();
    tick();
    srst <= 1'b1;
    tick(10);
    srst <= 1'b0;
    #1;
    note(0, pmem_map_pkg::RESET_VECTOR);
    for (int i = 0; i < 40 && config_ready !== 1'b1; i++)
    begin
      tick();
      #1;
    end
    note(12, 21'h1);
  endtask
  task automatic visit(logic [20:0] a);
    logic ext, hi;
    logic [20:0] ea;
    logic [7:0] dv;
    hi = a >= FSZ;
    ext = hi && m != pmem_map_pkg::MODE_INTERNAL;
    ea = (v[3] ? a - FSZ : a) & (m == pmem_map_pkg::MODE_EXT12 ? 21'hfff :
      m == pmem_map_pkg::MODE_EXT16 ? 21'hffff : 21'hfffff);
    dv = 8'($urandom);
    tick();
    pc_load <= 1'b1;
    pc_target <= a;
    table_addr <= a;
    data_write <= 1'b1;
    data_addr <= a[7:0];
    data_wdata <= dv;
    tick();
    pc_load <= 1'b0;
    data_write <= 1'b0;
    tick(3);
    #1;
    note(0, a);
    note(2, ext ? 21'(ea[15:0] ^ 16'h5a5a) : hi ? 21'h0 :
      21'({fbyte(a | 21'h1), fbyte(a)}));
    note(11, 21'(ext));
    note(3, 21'(ext));
    note(4, 21'(hi && m == pmem_map_pkg::MODE_INTERNAL));
    note(10, 21'(dv));
    note(6, 21'(m != pmem_map_pkg::MODE_INTERNAL));
    if (ext)
    begin
      note(5, ea);
      note(7, 21'(v[6]));
      note(8, 21'(!v[7]));
      if (!v[7]) note(9, 21'(mc[5:4]));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(69713));
    do_reset();
    tick();
    irq_high <= 1'b1;
    irq_low <= 1'b1;
    tick();
    irq_high <= 1'b0;
    #1;
    note(0, pmem_map_pkg::HIGH_VECTOR);
    tick();
    irq_low <= 1'b0;
    pc_step <= 1'b1;
    #1;
    note(0, pmem_map_pkg::LOW_VECTOR);
    tick();
    pc_step <= 1'b0;
    #1;
    note(0, pmem_map_pkg::LOW_VECTOR + 21'h2);
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      cfg[4] = 8'($urandom);
      do_reset();
      reg_rd(pmem_map_pkg::ADDR_BUS_CONFIG, cfg[4] & 8'hf8);
      reg_rd(pmem_map_pkg::ADDR_CONFIG_WORD1, cfg[0]);
      reg_rd(pmem_map_pkg::ADDR_CONFIG_WORD2, cfg[2]);
      v = {2'($urandom), m, 1'($urandom), 3'h5};
      mc = 8'($urandom);
      reg_wr(pmem_map_pkg::ADDR_BUS_CONFIG, v);
      reg_wr(pmem_map_pkg::ADDR_BUS_CONFIG, ~v);
      reg_wr(pmem_map_pkg::ADDR_MEM_CONTROL, mc);
      reg_rd(pmem_map_pkg::ADDR_BUS_CONFIG, v & 8'hf8);
      reg_rd(pmem_map_pkg::ADDR_STATUS, 8'h04);
      reg_rd(pmem_map_pkg::ADDR_MEM_CONTROL, mc);
      reg_rd(4'hf, 8'h0);
      visit(21'($urandom % 32'(FSZ - 21'h8)) & 21'h1ffffe);
      visit(FSZ + (21'($urandom) & 21'h0ffffe));
    end
    ->look;
    #1;
    summarize();
  end
endmodule // pmem_decoder_tb

// *** logic/addr_router.sv ***
// splits one program address between flash, external bus and zero fill
module addr_router #(
  parameter logic [20:0] FLASH_SIZE = 21'h020000
) (
  input wire logic [20:0] addr,
  input wire pmem_map_pkg::bus_config_type cfg,
  input wire logic pin80,
  output pmem_map_pkg::route_type route
);
  function automatic logic [20:0] width_mask(input logic [1:0] mode);
    unique case (mode)
      pmem_map_pkg::MODE_EXT12: width_mask = 21'h000fff;
      pmem_map_pkg::MODE_EXT16: width_mask = 21'h00ffff;
      default: width_mask = 21'h0fffff;
    endcase
  endfunction

  logic ext_mode;
  logic [20:0] shifted;
  always_comb
  begin
    ext_mode = pin80 && (cfg.bus_mode_select != pmem_map_pkg::MODE_INTERNAL);
    shifted = cfg.address_shift_enable ? addr - FLASH_SIZE : addr;
    route.internal_sel = (addr < FLASH_SIZE);
    route.external_sel = ext_mode && (addr >= FLASH_SIZE);
    route.zero_fill = !ext_mode && (addr >= FLASH_SIZE);
    route.ext_addr = route.external_sel ?
      (shifted & width_mask(cfg.bus_mode_select)) : 21'h000000;
  end
endmodule // addr_router

// *** logic/config_loader.sv ***
// walks the eight configuration bytes at reset release, low address first
module config_loader #(
  parameter logic [20:0] FLASH_SIZE = 21'h020000
) (
  input wire logic core_clk,
  input wire logic srst,
  output logic [20:0] load_addr,
  output logic load_strobe,
  output logic [2:0] load_index,
  output logic load_busy
);
  logic [3:0] count;
  initial assert (FLASH_SIZE >= 21'h000008)
    else $error("flash too small");

  always_ff @(posedge core_clk)
  begin
    if (srst)
      count <= 4'h0;
    else if (count != 4'h8)
      count <= count + 4'h1;
  end

  assign load_busy = (count != 4'h8);
  assign load_strobe = load_busy;
  assign load_index = count[2:0];
  assign load_addr = FLASH_SIZE - pmem_map_pkg::CONFIG_AREA_SIZE
    + {18'h00000, count[2:0]};
endmodule // config_loader

// *** logic/pmem_decoder.sv ***
// Operation
// - fetch addresses come from a 21-bit counter over a 2-Mbyte space.
// - unimplemented space up to 2 Mbytes reads as an all-zero word.
// - every reset loads the counter with address zero.
// - interrupts vector to 0008h high priority and 0018h low priority.
// - top four flash words hold configuration, copied in at reset.
// - config bytes ascend from word one low byte; word four reserved.
// - configuration area sits at the top eight bytes of flash.
// - bits 5:4 pick internal-only or 12, 16, 20-bit external address.
// - internal-only mode uses flash only, above reads give zeros.
// - 64-pin parts are internal-only; bus config bits exist on 80-pin.
// - extended mode maps low addresses to flash, high to external.
// - data RAM stays reachable in every program memory mode.
// - program and data buses are separate and run concurrently.
// - bit 7 set disables wait states; clear uses control field count.
// - bit 6 selects 16-bit data width, clear selects 8-bit.
// - bit 3 set shifts external addresses to start at zero.
// - shifting subtracts on-chip flash size from the counter.
//
// The plain strobed port and the placing of the registers were decided locally.
module pmem_decoder #(
  parameter logic [20:0] FLASH_SIZE = 21'h020000,
  parameter bit PIN80 = 1'b1
) (
  input wire logic core_clk,
  input wire logic srst,
  // plain register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // program counter control from the core
  input wire logic pc_load,
  input wire logic [20:0] pc_target,
  input wire logic pc_step,
  input wire logic irq_high,
  input wire logic irq_low,
  output logic [20:0] pc,
  // fetch side
  output logic [15:0] fetch_word,
  output logic fetch_external,
  // table access port
  input wire logic [20:0] table_addr,
  output logic table_external,
  output logic table_zero,
  // on-chip flash word read
  output logic [20:0] flash_addr,
  input wire logic [15:0] flash_word,
  // external bus controls
  output logic [20:0] ext_addr,
  output logic ext_enable,
  output logic ext_wide,
  output logic ext_wait_enable,
  output logic [1:0] ext_wait_count,
  input wire logic [15:0] ext_word,
  // data side runs apart from program space
  input wire logic [7:0] data_addr,
  input wire logic data_write,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic config_ready
);
  // bit 0 of the pc is held low, so flash must hold whole words
  if (FLASH_SIZE[0] != 1'b0 || FLASH_SIZE > 21'h100000)
  begin : g_size_check
    $error("flash size unsupported");
  end

  ////////////////////////////////////////////////////////////////////////
  logic [20:0] load_addr;
  logic load_strobe;
  logic [2:0] load_index;
  logic load_busy;
  logic [7:0] bus_config;
  logic written;
  logic [7:0] mem_control;
  logic [7:0] config_word1;
  logic [7:0] config_word2;
  logic [7:0] data_ram [0:255];
  pmem_map_pkg::bus_config_type cfg;
  pmem_map_pkg::route_type fetch_route;
  pmem_map_pkg::route_type table_route;
  logic [20:0] fetch_addr;

  config_loader #(.FLASH_SIZE(FLASH_SIZE)) loader (
    .core_clk(core_clk),
    .srst(srst),
    .load_addr(load_addr),
    .load_strobe(load_strobe),
    .load_index(load_index),
    .load_busy(load_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration copy; byte 4 is the low byte of word three
  logic [7:0] flash_byte;
  assign flash_byte = load_addr[0] ? flash_word[15:8] : flash_word[7:0];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bus_config <= pmem_map_pkg::CONFIG_RESET;
      written <= 1'b0;
    end
    else if (load_strobe &&
      load_index == 3'(pmem_map_pkg::CFG3_LOW_BYTE))
      bus_config <= flash_byte & pmem_map_pkg::CONFIG_MASK;
    else if (reg_write && reg_addr == pmem_map_pkg::ADDR_BUS_CONFIG &&
      !written && !load_busy && PIN80)
    begin
      bus_config <= reg_wdata & pmem_map_pkg::CONFIG_MASK;
      written <= 1'b1;
    end
  end

  // words one and two are kept for readback only; word four is reserved
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      config_word1 <= 8'hff;
      config_word2 <= 8'hff;
    end
    else if (load_strobe && load_index == 3'h0)
      config_word1 <= flash_byte;
    else if (load_strobe && load_index == 3'h2)
      config_word2 <= flash_byte;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      mem_control <= 8'h00;
    else if (reg_write && reg_addr == pmem_map_pkg::ADDR_MEM_CONTROL)
      mem_control <= reg_wdata;
  end

  // 64-pin parts see the bus mode forced to internal-only
  always_comb
  begin
    cfg.wait_disable = bus_config[pmem_map_pkg::WAIT_BIT];
    cfg.data_width_select = bus_config[pmem_map_pkg::WIDTH_BIT];
    cfg.bus_mode_select = PIN80 ?
      bus_config[pmem_map_pkg::MODE_HI:pmem_map_pkg::MODE_LO] :
      pmem_map_pkg::MODE_INTERNAL;
    cfg.address_shift_enable = bus_config[pmem_map_pkg::SHIFT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter; bit 0 is held at zero for word alignment
  always_ff @(posedge core_clk)
  begin
    if (srst || load_busy)
      pc <= pmem_map_pkg::RESET_VECTOR;
    else if (irq_high)
      pc <= pmem_map_pkg::HIGH_VECTOR;
    else if (irq_low)
      pc <= pmem_map_pkg::LOW_VECTOR;
    else if (pc_load)
      pc <= {pc_target[20:1], 1'b0};
    else if (pc_step)
      pc <= pc + 21'h000002;
  end

  ////////////////////////////////////////////////////////////////////////
  // routing: loader owns the flash port until configuration is in
  assign fetch_addr = pc;
  addr_router #(.FLASH_SIZE(FLASH_SIZE)) fetch_router (
    .addr(fetch_addr),
    .cfg(cfg),
    .pin80(PIN80),
    .route(fetch_route)
  );
  addr_router #(.FLASH_SIZE(FLASH_SIZE)) table_router (
    .addr(table_addr),
    .cfg(cfg),
    .pin80(PIN80),
    .route(table_route)
  );

  assign flash_addr = load_busy ? {load_addr[20:1], 1'b0} : fetch_addr;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      fetch_word <= 16'h0000;
    else if (fetch_route.zero_fill || load_busy)
      fetch_word <= 16'h0000;
    else if (fetch_route.external_sel)
      fetch_word <= ext_word;
    else
      fetch_word <= flash_word;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ext_addr <= 21'h000000;
      fetch_external <= 1'b0;
      table_external <= 1'b0;
      table_zero <= 1'b0;
      ext_enable <= 1'b0;
      ext_wide <= 1'b0;
      ext_wait_enable <= 1'b0;
      ext_wait_count <= 2'h0;
    end
    else
    begin
      ext_addr <= fetch_route.ext_addr;
      fetch_external <= fetch_route.external_sel;
      table_external <= table_route.external_sel;
      table_zero <= table_route.zero_fill;
      ext_enable <= cfg.bus_mode_select != pmem_map_pkg::MODE_INTERNAL;
      ext_wide <= cfg.data_width_select;
      ext_wait_enable <= !cfg.wait_disable;
      ext_wait_count <= cfg.wait_disable ? 2'h0 :
        mem_control[pmem_map_pkg::WAIT_CNT_HI:pmem_map_pkg::WAIT_CNT_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data RAM on its own bus, not gated by any program mode
  always_ff @(posedge core_clk)
  begin
    if (data_write)
      data_ram[data_addr] <= data_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      data_rdata <= 8'h00;
    else
      data_rdata <= data_ram[data_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_read)
      unique case (reg_addr)
        pmem_map_pkg::ADDR_BUS_CONFIG: reg_rdata <= bus_config;
        pmem_map_pkg::ADDR_MEM_CONTROL: reg_rdata <= mem_control;
        pmem_map_pkg::ADDR_STATUS:
          reg_rdata <= {5'h00, written, fetch_external, load_busy};
        pmem_map_pkg::ADDR_CONFIG_WORD1: reg_rdata <= config_word1;
        pmem_map_pkg::ADDR_CONFIG_WORD2: reg_rdata <= config_word2;
        default: reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  assign config_ready = !load_busy;

  ////////////////////////////////////////////////////////////////////////
  a_reset_vector: assert property (@(posedge core_clk)
    srst |=> pc == 21'h000000)
    else $error("pc not at reset vector");
  a_high_vector: assert property (@(posedge core_clk) disable iff (srst)
    (irq_high && !load_busy) |=> pc == 21'h000008)
    else $error("high vector wrong");
  a_low_vector: assert property (@(posedge core_clk) disable iff (srst)
    (irq_low && !irq_high && !load_busy) |=> pc == 21'h000018)
    else $error("low vector wrong");
  a_zero_fill: assert property (@(posedge core_clk) disable iff (srst)
    fetch_route.zero_fill |=> fetch_word == 16'h0000)
    else $error("unimplemented space not zero");
  a_low_bits: assert property (@(posedge core_clk) disable iff (srst)
    bus_config[2:0] == 3'h0)
    else $error("config low bits set");
  a_write_once: assert property (@(posedge core_clk) disable iff (srst)
    (written && !load_busy) |=> $stable(bus_config))
    else $error("config changed after write");
  a_config_load: assert property (@(posedge core_clk) disable iff (srst)
    (load_busy && load_index == 3'h4) |=>
    bus_config == ($past(flash_word[7:0]) & pmem_map_pkg::CONFIG_MASK))
    else $error("config byte not copied");
  a_load_time: assert property (@(posedge core_clk)
    $fell(srst) |-> ##[7:8] !load_busy)
    else $error("load too long");
  a_ext_route: assert property (@(posedge core_clk) disable iff (srst)
    fetch_external |-> ext_enable && $past(fetch_addr) >= FLASH_SIZE)
    else $error("external below flash top");
  a_wait_count: assert property (@(posedge core_clk) disable iff (srst)
    cfg.wait_disable |=> ext_wait_count == 2'h0)
    else $error("wait count with waits off");
  a_shift_addr: assert property (@(posedge core_clk) disable iff (srst)
    (fetch_route.external_sel && cfg.address_shift_enable &&
     cfg.bus_mode_select == 2'h0) |=>
    ext_addr == (($past(fetch_addr) - FLASH_SIZE) & 21'h0fffff))
    else $error("shift wrong");
  a_config_addr: assert property (@(posedge core_clk)
    disable iff (srst)
    (load_busy && load_index == 3'h4) |->
    flash_addr == FLASH_SIZE - 21'h000004)
    else $error("config word three not at flash top");
  a_word1_copy: assert property (@(posedge core_clk)
    disable iff (srst)
    (load_busy && load_index == 3'h0) |=>
    config_word1 == $past(flash_word[7:0]))
    else $error("first config word not copied");
  a_word2_copy: assert property (@(posedge core_clk)
    disable iff (srst)
    (load_busy && load_index == 3'h2) |=>
    config_word2 == $past(flash_word[7:0]))
    else $error("second config word not copied");
  a_load_pc: assert property (@(posedge core_clk) disable iff (srst)
    load_busy |=> pc == 21'h000000)
    else $error("pc moved during config load");
  a_pc_even: assert property (@(posedge core_clk) disable iff (srst)
    pc[0] == 1'b0)
    else $error("pc not word aligned");
  a_internal_bus: assert property (@(posedge core_clk)
    disable iff (srst)
    (cfg.bus_mode_select == pmem_map_pkg::MODE_INTERNAL) |=>
    (!ext_enable && !fetch_external && !table_external))
    else $error("external bus used in internal mode");
  a_bus_width: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> ext_wide == $past(bus_config[pmem_map_pkg::WIDTH_BIT]))
    else $error("data width not from config");
  a_wait_enable: assert property (@(posedge core_clk)
    disable iff (srst)
    1'b1 |=> ext_wait_enable == !$past(bus_config[pmem_map_pkg::WAIT_BIT]))
    else $error("wait enable not from config");
  a_shift_off: assert property (@(posedge core_clk)
    disable iff (srst)
    (fetch_route.external_sel && !cfg.address_shift_enable &&
     cfg.bus_mode_select == pmem_map_pkg::MODE_EXT20) |=>
    ext_addr == ($past(fetch_addr) & 21'h0fffff))
    else $error("unshifted address differs from pc");
  a_mask_12: assert property (@(posedge core_clk)
    disable iff (srst)
    (fetch_route.external_sel &&
     cfg.bus_mode_select == pmem_map_pkg::MODE_EXT12) |=>
    ext_addr[20:12] == 9'h000)
    else $error("12-bit address too wide");
  a_mask_16: assert property (@(posedge core_clk)
    disable iff (srst)
    (fetch_route.external_sel &&
     cfg.bus_mode_select == pmem_map_pkg::MODE_EXT16) |=>
    ext_addr[20:16] == 5'h00)
    else $error("16-bit address too wide");
  a_ram_read: assert property (@(posedge core_clk)
    disable iff (srst)
    data_write ##1 (!data_write && $stable(data_addr)) |=>
    data_rdata == $past(data_wdata, 2))
    else $error("data RAM read wrong");
  c_ext_fetch: cover property (@(posedge core_clk) fetch_external);
  c_irq: cover property (@(posedge core_clk) irq_high ##1 irq_low);
  c_cfg_write: cover property (@(posedge core_clk) $rose(written));
  c_zero: cover property (@(posedge core_clk) table_zero);
  c_shift: cover property (@(posedge core_clk)
    fetch_external && cfg.address_shift_enable);
endmodule // pmem_decoder

// *** logic/pmem_map_pkg.sv ***
package pmem_map_pkg;
  // register map of the plain port
  localparam logic [3:0] ADDR_BUS_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_MEM_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CONFIG_WORD1 = 4'h3;
  localparam logic [3:0] ADDR_CONFIG_WORD2 = 4'h4;
  // external_bus_config_low fields
  localparam int WAIT_BIT = 7;
  localparam int WIDTH_BIT = 6;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int SHIFT_BIT = 3;
  localparam logic [7:0] CONFIG_RESET = 8'hf8;
  localparam logic [7:0] CONFIG_MASK = 8'hf8;
  // memory_control_reg wait count field
  localparam int WAIT_CNT_HI = 5;
  localparam int WAIT_CNT_LO = 4;
  // program space
  localparam int PC_WIDTH = 21;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] LOW_VECTOR = 21'h000018;
  localparam logic [20:0] CONFIG_AREA_SIZE = 21'h000008;
  localparam logic [1:0] MODE_INTERNAL = 2'h3;
  localparam logic [1:0] MODE_EXT12 = 2'h2;
  localparam logic [1:0] MODE_EXT16 = 2'h1;
  localparam logic [1:0] MODE_EXT20 = 2'h0;
  // configuration byte offsets within the area, low byte first
  localparam int CFG_BYTES = 8;
  localparam int CFG3_LOW_BYTE = 4;
  typedef struct packed {
    logic wait_disable;
    logic data_width_select;
    logic [1:0] bus_mode_select;
    logic address_shift_enable;
  } bus_config_type;
  typedef struct packed {
    logic internal_sel;
    logic external_sel;
    logic zero_fill;
    logic [20:0] ext_addr;
  } route_type;
endpackage
